// File: hw/led_gp_pkg.sv
package led_gp_pkg;

  // ----------------------------------------
  // pin modes, chosen outside this block
  // ----------------------------------------
  typedef enum logic [1:0] {
    GP_PWM,
    GP_OUTPUT,
    GP_ANALOG,
    GP_INPUT
  } gp_mode_e;

  // register access request, one cycle strobes
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // sampled state of one general-purpose pin
  typedef struct packed {
    logic [7:0] analog;
    logic       level;
  } gp_in_s;

endpackage

// File: hw/led_gp_regs.svh
`ifndef LED_GP_REGS_SVH
`define LED_GP_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_RED_INTENSITY     8'h18
`define ADDR_GREEN_INTENSITY   8'h19
`define ADDR_BLUE_INTENSITY    8'h1A
`define ADDR_PIN1_VALUE        8'h1B
`define ADDR_PIN2_VALUE        8'h1C
`define ADDR_PIN3_VALUE        8'h1D
`define ADDR_BOUNCE_WINDOW     8'h1E
`define ADDR_DOUBLE_PRESS      8'h1F
`define ADDR_COLOUR_FADE       8'h20
`define ADDR_PIN_FADE          8'h21

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define RST_ZERO               8'h00
`define RST_BOUNCE_WINDOW      8'h19
`define UNMAPPED_READ          8'h00
`define PIN_LEVEL_BIT          0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS          10
`define MS_TIME_NS             1000000
`define UNIT_TIME_MS           10
`define PWM_TOP                8'hFE

`endif

// File: hw/led_gp_timing_regs.sv
`include "led_gp_regs.svh"

module led_gp_timing_regs #(
  parameter int unsigned MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire led_gp_pkg::reg_req_s req,
  output logic               [7:0] rdata,
  output logic                     rdValid,
  input  wire led_gp_pkg::gp_mode_e gpMode [3],
  input  wire led_gp_pkg::gp_in_s  [2:0] gpIn,
  input  wire logic                rgbFitted,
  input  wire logic                stepCw,
  input  wire logic                stepCcw,
  input  wire logic                pushPress,
  output logic                     redPwm,
  output logic                     greenPwm,
  output logic                     bluePwm,
  output logic               [2:0] gpOut,
  output logic               [2:0] gpOe,
  output logic                     countCw,
  output logic                     countCcw,
  output logic                     doublePress
);

  typedef enum logic [1:0] {
    DIR_NONE,
    DIR_CW,
    DIR_CCW
  } dir_e;

  typedef enum logic {
    PRESS_IDLE,
    PRESS_ARMED
  } press_e;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [2:0][7:0] colour;
  logic [2:0][7:0] pinValue;
  logic      [7:0] bounceWindow;
  logic      [7:0] pressWindow;
  logic      [7:0] colourFade;
  logic      [7:0] pinFade;
  logic [2:0][7:0] next_colour;
  logic [2:0][7:0] next_pinValue;
  logic      [7:0] next_bounceWindow;
  logic      [7:0] next_pressWindow;
  logic      [7:0] next_colourFade;
  logic      [7:0] next_pinFade;
  logic      [7:0] next_rdata;

  // write decode
  always_comb
  begin
    next_colour       = colour;
    next_pinValue     = pinValue;
    next_bounceWindow = bounceWindow;
    next_pressWindow  = pressWindow;
    next_colourFade   = colourFade;
    next_pinFade      = pinFade;
    if (req.wr)
    begin
      case (req.addr)
        `ADDR_RED_INTENSITY:   next_colour[0]    = req.wdata;
        `ADDR_GREEN_INTENSITY: next_colour[1]    = req.wdata;
        `ADDR_BLUE_INTENSITY:  next_colour[2]    = req.wdata;
        `ADDR_PIN1_VALUE:      next_pinValue[0]  = req.wdata;
        `ADDR_PIN2_VALUE:      next_pinValue[1]  = req.wdata;
        `ADDR_PIN3_VALUE:      next_pinValue[2]  = req.wdata;
        `ADDR_BOUNCE_WINDOW:   next_bounceWindow = req.wdata;
        `ADDR_DOUBLE_PRESS:    next_pressWindow  = req.wdata;
        `ADDR_COLOUR_FADE:     next_colourFade   = req.wdata;
        `ADDR_PIN_FADE:        next_pinFade      = req.wdata;
        default:               next_colour       = colour;
      endcase
    end
  end

  // pin value read depends on pin mode
  function automatic logic [7:0] pinRead(input led_gp_pkg::gp_mode_e mode, input led_gp_pkg::gp_in_s pin,
                                         input logic [7:0] stored);
    logic [7:0] value;
    value = stored;
    case (mode)
      led_gp_pkg::GP_ANALOG: value = pin.analog;
      led_gp_pkg::GP_INPUT:  value = {7'h00, pin.level};
      default:               value = stored;
    endcase
    return value;
  endfunction

  // read mux
  always_comb
  begin
    case (req.addr)
      `ADDR_RED_INTENSITY:   next_rdata = colour[0];
      `ADDR_GREEN_INTENSITY: next_rdata = colour[1];
      `ADDR_BLUE_INTENSITY:  next_rdata = colour[2];
      `ADDR_PIN1_VALUE:      next_rdata = pinRead(gpMode[0], gpIn[0], pinValue[0]);
      `ADDR_PIN2_VALUE:      next_rdata = pinRead(gpMode[1], gpIn[1], pinValue[1]);
      `ADDR_PIN3_VALUE:      next_rdata = pinRead(gpMode[2], gpIn[2], pinValue[2]);
      `ADDR_BOUNCE_WINDOW:   next_rdata = bounceWindow;
      `ADDR_DOUBLE_PRESS:    next_rdata = pressWindow;
      `ADDR_COLOUR_FADE:     next_rdata = colourFade;
      `ADDR_PIN_FADE:        next_rdata = pinFade;
      default:               next_rdata = `UNMAPPED_READ;
    endcase
    if (!req.rd)
    begin
      next_rdata = rdata;
    end
  end

  // register storage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      colour       <= {3{`RST_ZERO}};
      pinValue     <= {3{`RST_ZERO}};
      bounceWindow <= `RST_BOUNCE_WINDOW;
      pressWindow  <= `RST_ZERO;
      colourFade   <= `RST_ZERO;
      pinFade      <= `RST_ZERO;
      rdata        <= `RST_ZERO;
      rdValid      <= 1'b0;
    end
    else
    begin
      colour       <= next_colour;
      pinValue     <= next_pinValue;
      bounceWindow <= next_bounceWindow;
      pressWindow  <= next_pressWindow;
      colourFade   <= next_colourFade;
      pinFade      <= next_pinFade;
      rdata        <= next_rdata;
      rdValid      <= req.rd;
    end
  end

  // ----------------------------------------
  // millisecond and 10 ms enables
  // ----------------------------------------
  logic [16:0] msCount;
  logic  [3:0] unitCount;
  logic        msTick;
  logic        unitTick;
  logic [16:0] next_msCount;
  logic  [3:0] next_unitCount;

  // divider next state
  always_comb
  begin
    msTick         = (msCount == 17'(MS_CYCLES - 1));
    unitTick       = msTick && (unitCount == 4'(`UNIT_TIME_MS - 1));
    next_msCount   = msTick ? 17'h00000 : msCount + 17'h00001;
    next_unitCount = unitCount;
    if (msTick)
    begin
      next_unitCount = unitTick ? 4'h0 : unitCount + 4'h1;
    end
  end

  // divider registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      msCount   <= 17'h00000;
      unitCount <= 4'h0;
    end
    else
    begin
      msCount   <= next_msCount;
      unitCount <= next_unitCount;
    end
  end

  // ----------------------------------------
  // rotation anti-bounce
  // ----------------------------------------
  dir_e       lastDir;
  dir_e       next_lastDir;
  logic [7:0] bounceTimer;
  logic [7:0] next_bounceTimer;
  logic       next_countCw;
  logic       next_countCcw;

  // opposite steps dropped while the window runs
  always_comb
  begin
    next_lastDir     = lastDir;
    next_bounceTimer = bounceTimer;
    next_countCw     = 1'b0;
    next_countCcw    = 1'b0;
    if (unitTick && bounceTimer != 8'h00)
    begin
      next_bounceTimer = bounceTimer - 8'h01;
    end
    if (stepCw && !(lastDir == DIR_CCW && bounceTimer != 8'h00))
    begin
      next_countCw     = 1'b1;
      next_lastDir     = DIR_CW;
      next_bounceTimer = bounceWindow;
    end
    else if (stepCcw && !(lastDir == DIR_CW && bounceTimer != 8'h00))
    begin
      next_countCcw    = 1'b1;
      next_lastDir     = DIR_CCW;
      next_bounceTimer = bounceWindow;
    end
  end

  // anti-bounce registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lastDir     <= DIR_NONE;
      bounceTimer <= 8'h00;
      countCw     <= 1'b0;
      countCcw    <= 1'b0;
    end
    else
    begin
      lastDir     <= next_lastDir;
      bounceTimer <= next_bounceTimer;
      countCw     <= next_countCw;
      countCcw    <= next_countCcw;
    end
  end

  // ----------------------------------------
  // double press detection
  // ----------------------------------------
  press_e     pressState;
  press_e     next_pressState;
  logic [7:0] pressTimer;
  logic [7:0] next_pressTimer;
  logic       next_doublePress;

  // second press inside the window reports once
  always_comb
  begin
    next_pressState  = pressState;
    next_pressTimer  = pressTimer;
    next_doublePress = 1'b0;
    case (pressState)
      PRESS_IDLE:
      begin
        if (pushPress && pressWindow != 8'h00)
        begin
          next_pressState = PRESS_ARMED;
          next_pressTimer = pressWindow;
        end
      end
      PRESS_ARMED:
      begin
        if (pressWindow == 8'h00)
        begin
          next_pressState = PRESS_IDLE;
        end
        else if (pushPress)
        begin
          next_doublePress = 1'b1;
          next_pressState  = PRESS_IDLE;
        end
        else if (unitTick)
        begin
          next_pressTimer = pressTimer - 8'h01;
          if (pressTimer == 8'h01)
          begin
            next_pressState = PRESS_IDLE;
          end
        end
      end
      default:
      begin
        next_pressState = PRESS_IDLE;
      end
    endcase
  end

  // double press registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pressState  <= PRESS_IDLE;
      pressTimer  <= 8'h00;
      doublePress <= 1'b0;
    end
    else
    begin
      pressState  <= next_pressState;
      pressTimer  <= next_pressTimer;
      doublePress <= next_doublePress;
    end
  end

  // ----------------------------------------
  // colour and pin channels
  // ----------------------------------------
  logic [2:0] colourPwm;
  logic [2:0] pinPwm;
  logic [2:0] pinIsPwm;

  for (genvar i = 0; i < 3; i++)
  begin : g_chan
    assign pinIsPwm[i] = (gpMode[i] == led_gp_pkg::GP_PWM);

    pwm_fade_channel u_colour (
      .clk        (clk),
      .rst_n      (rst_n),
      .msTick     (msTick),
      .fadeEnable (rgbFitted),
      .stepPeriod (colourFade),
      .target     (colour[i]),
      .duty       (),
      .pwmOut     (colourPwm[i])
    );

    pwm_fade_channel u_pin (
      .clk        (clk),
      .rst_n      (rst_n),
      .msTick     (msTick),
      .fadeEnable (pinIsPwm[i]),
      .stepPeriod (pinFade),
      .target     (pinValue[i]),
      .duty       (),
      .pwmOut     (pinPwm[i])
    );
  end

  // pin drive per mode
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      case (gpMode[i])
        led_gp_pkg::GP_PWM:    gpOut[i] = pinPwm[i];
        led_gp_pkg::GP_OUTPUT: gpOut[i] = pinValue[i][`PIN_LEVEL_BIT];
        default:               gpOut[i] = 1'b0;
      endcase
      gpOe[i] = (gpMode[i] == led_gp_pkg::GP_PWM) || (gpMode[i] == led_gp_pkg::GP_OUTPUT);
    end
  end

  assign redPwm   = colourPwm[0];
  assign greenPwm = colourPwm[1];
  assign bluePwm  = colourPwm[2];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  opposite_step_drop_a: assert property (lastDir == DIR_CW && bounceTimer != 8'h00 && stepCcw && !stepCw
      |=> !countCcw)
    else $error("reverse step counted inside bounce window");
  bounce_reload_a: assert property (countCw || countCcw |-> bounceTimer == $past(bounceWindow))
    else $error("bounce window not loaded after step");
  press_disabled_a: assert property (pressWindow == 8'h00 && $past(pressWindow) == 8'h00
      && $past(pressWindow, 2) == 8'h00 |-> !doublePress)
    else $error("double press reported while disabled");
  press_pair_a: assert property (pressState == PRESS_ARMED && pushPress && pressWindow != 8'h00
      |=> doublePress)
    else $error("second press in window not reported");
  pin_output_level_a: assert property (gpMode[1] == led_gp_pkg::GP_OUTPUT |-> gpOe[1]
      && gpOut[1] == pinValue[1][`PIN_LEVEL_BIT])
    else $error("output pin does not follow written level");
  pin_input_read_a: assert property (req.rd && req.addr == `ADDR_PIN1_VALUE
      && gpMode[0] == led_gp_pkg::GP_INPUT |=> rdValid && rdata == {7'h00, $past(gpIn[0].level)})
    else $error("input pin read wrong level");
  pin_analog_read_a: assert property (req.rd && req.addr == `ADDR_PIN3_VALUE
      && gpMode[2] == led_gp_pkg::GP_ANALOG |=> rdata == $past(gpIn[2].analog))
    else $error("analog pin read wrong sample");
  reg_write_read_a: assert property (req.wr && req.addr == `ADDR_RED_INTENSITY ##1 !req.wr ##1 req.rd
      && req.addr == `ADDR_RED_INTENSITY && !req.wr |=> rdata == $past(req.wdata, 3))
    else $error("red intensity did not read back");
  unit_tick_spacing_a: assert property (unitTick |=> !unitTick)
    else $error("10 ms enable longer than one cycle");

  step_accept_c: cover property (countCw ##[1:50] countCcw);
  double_press_c: cover property (doublePress);
  bounce_drop_c: cover property (lastDir == DIR_CW && bounceTimer != 8'h00 && stepCcw);
  read_back_c: cover property (rdValid && rdata != 8'h00);

endmodule

// File: hw/pwm_fade_channel.sv
`include "led_gp_regs.svh"

module pwm_fade_channel (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       msTick,
  input  wire logic       fadeEnable,
  input  wire logic [7:0] stepPeriod,
  input  wire logic [7:0] target,
  output logic      [7:0] duty,
  output logic            pwmOut
);

  logic [7:0] pwmCount;
  logic [7:0] msCount;
  logic [7:0] next_pwmCount;
  logic [7:0] next_msCount;
  logic [7:0] next_duty;
  logic       next_pwmOut;

  // ----------------------------------------
  // pwm and fade next state
  // ----------------------------------------
  always_comb
  begin
    next_pwmCount = (pwmCount == `PWM_TOP) ? 8'h00 : pwmCount + 8'h01;
    next_pwmOut   = (pwmCount < duty);
    next_duty     = duty;
    next_msCount  = msCount;
    if (!fadeEnable || stepPeriod == 8'h00)
    begin
      next_duty    = target;
      next_msCount = 8'h00;
    end
    else if (duty == target)
    begin
      next_msCount = 8'h00;
    end
    else if (msTick)
    begin
      if (msCount == stepPeriod - 8'h01)
      begin
        next_msCount = 8'h00;
        next_duty    = (duty < target) ? duty + 8'h01 : duty - 8'h01;
      end
      else
      begin
        next_msCount = msCount + 8'h01;
      end
    end
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pwmCount <= 8'h00;
      msCount  <= 8'h00;
      duty     <= 8'h00;
      pwmOut   <= 1'b0;
    end
    else
    begin
      pwmCount <= next_pwmCount;
      msCount  <= next_msCount;
      duty     <= next_duty;
      pwmOut   <= next_pwmOut;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  fade_single_step_a: assert property (fadeEnable && stepPeriod != 8'h00 && $past(fadeEnable)
      && $past(stepPeriod) != 8'h00 && $stable(stepPeriod) |->
      (duty - $past(duty) == 8'h01) || ($past(duty) - duty == 8'h01) || $stable(duty))
    else $error("fading duty jumped by more than one");
  zero_period_snap_a: assert property (stepPeriod == 8'h00 |=> duty == $past(target))
    else $error("zero fade period did not apply target at once");
  duty_off_dark_a: assert property ((duty == 8'h00) [*2] |-> !pwmOut)
    else $error("zero duty produced a high output");
  duty_full_on_a: assert property ((duty == 8'hFF) [*2] |-> pwmOut)
    else $error("full duty produced a low output");

endmodule

// File: tb/reg_host_model.sv
module reg_host_model (
  input  wire logic            clk,
  output led_gp_pkg::reg_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // host side of the register strobe port
  // ----------------------------------------
  // idle bus at time zero
  initial
  begin
    req = '0;
  end

  // one strobe raised after an edge, taken at the next edge, then released
  task automatic access(
    input logic       wr,
    input logic       rd,
    input logic [7:0] addr,
    input logic [7:0] data
  );
    begin
      @(posedge clk);
      req <= '{wr: wr, rd: rd, addr: addr, wdata: data};
      @(posedge clk);
      // released lines show inverted values, not the last ones
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    end
  endtask
endmodule

// File: tb/tb.sv
`include "led_gp_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and bookkeeping
  // ----------------------------------------
  logic                     clk        = 1'b0;
  logic                     rst_n      = 1'b0;
  led_gp_pkg::reg_req_s     req;
  led_gp_pkg::gp_mode_e     gpMode [3];
  led_gp_pkg::gp_in_s [2:0] gpIn;
  logic                     rgbFitted;
  logic                     stepCw;
  logic                     stepCcw;
  logic                     pushPress;
  logic               [7:0] rdata;
  logic                     rdValid;
  logic                     redPwm;
  logic                     greenPwm;
  logic                     bluePwm;
  logic               [2:0] gpOut;
  logic               [2:0] gpOe;
  logic                     countCw;
  logic                     countCcw;
  logic                     doublePress;
  int                       fails      = 0;
  int                       num_checks = 0;
  int                       nCw        = 0;
  int                       nCcw       = 0;
  int                       nDp        = 0;
  logic               [7:0] expQ [$];
  logic               [7:0] lfsrState  = 8'h3E;
  logic               [7:0] v;
  int                       k;

  // 10 ms unit shortened to 100 cycles
  led_gp_timing_regs #(.MS_CYCLES(10)) led_gp_timing_regs_inst (
    .clk         (clk),
    .rst_n       (rst_n),
    .req         (req),
    .rdata       (rdata),
    .rdValid     (rdValid),
    .gpMode      (gpMode),
    .gpIn        (gpIn),
    .rgbFitted   (rgbFitted),
    .stepCw      (stepCw),
    .stepCcw     (stepCcw),
    .pushPress   (pushPress),
    .redPwm      (redPwm),
    .greenPwm    (greenPwm),
    .bluePwm     (bluePwm),
    .gpOut       (gpOut),
    .gpOe        (gpOe),
    .countCw     (countCw),
    .countCcw    (countCcw),
    .doublePress (doublePress)
  );

  reg_host_model reg_host_model_inst (
    .clk (clk),
    .req (req)
  );

  always #5 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    begin
      num_checks++;
      if (got !== exp)
      begin
        fails++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // eight bit lfsr for data values
  function automatic void rnd(output logic [7:0] r);
    begin
      lfsrState = {lfsrState[6:0], lfsrState[7] ^ lfsrState[5] ^ lfsrState[4] ^ lfsrState[3]};
      r = lfsrState;
    end
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_host_model_inst.access(1'b1, 1'b0, a, d);
  endtask

  // note the expected answer, then issue the read
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    begin
      expQ.push_back(e);
      reg_host_model_inst.access(1'b0, 1'b1, a, 8'h00);
    end
  endtask

  // bounded wait until every read got its answer
  task automatic drain;
    int n;
    begin
      n = 0;
      while (expQ.size() != 0 && n < 20)
      begin
        @(negedge clk);
        n++;
      end
      if (expQ.size() != 0)
      begin
        fails++;
        $display("[FAIL] t=%0t missing=%h exp=%h", $time, expQ.size(), expQ[0]);
        end_of_test();
      end
    end
  endtask

  // one cycle event pulse: 0 cw step, 1 ccw step, 2 push
  task automatic pulse(input int which);
    begin
      @(posedge clk);
      stepCw    <= (which == 0);
      stepCcw   <= (which == 1);
      pushPress <= (which == 2);
      @(posedge clk);
      stepCw    <= 1'b0;
      stepCcw   <= 1'b0;
      pushPress <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // high cycles of one pwm output over n cycles: 0..2 colours, 3..5 pins
  task automatic count_high(input int ch, input int n, output int c);
    begin
      c = 0;
      repeat (n)
      begin
        @(negedge clk);
        c += (ch == 0) ? redPwm : (ch == 1) ? greenPwm : (ch == 2) ? bluePwm : gpOut[ch - 3];
      end
    end
  endtask

  // ----------------------------------------
  // monitor: read answers and event pulses
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (rdValid === 1'b1)
    begin
      if (expQ.size() == 0)
        check(rdata, ~rdata);
      else
        check(rdata, expQ.pop_front());
    end
    nCw  += (countCw === 1'b1);
    nCcw += (countCcw === 1'b1);
    nDp  += (doublePress === 1'b1);
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    gpMode    = '{led_gp_pkg::GP_PWM, led_gp_pkg::GP_PWM, led_gp_pkg::GP_PWM};
    gpIn      = '0;
    rgbFitted = 1'b1;
    stepCw    = 1'b0;
    stepCcw   = 1'b0;
    pushPress = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 8'h18; a <= 8'h21; a++)
      rd_exp(a[7:0], (a == 8'h1E) ? `RST_BOUNCE_WINDOW : `RST_ZERO);
    rd_exp(8'h30, `UNMAPPED_READ);
    drain();
    $display("test reset_values done");
    // default window of 25 units holds off reverse steps
    pulse(0);
    check(nCw[7:0], 8'h01);
    repeat (1000) @(posedge clk);
    pulse(1);
    check(nCcw[7:0], 8'h00);
    pulse(0);
    wr(`ADDR_BOUNCE_WINDOW, 8'h02);
    pulse(0);
    check(nCw[7:0], 8'h03);
    repeat (20) @(posedge clk);
    pulse(1);
    check(nCcw[7:0], 8'h00);
    repeat (250) @(posedge clk);
    pulse(1);
    check(nCcw[7:0], 8'h01);
    $display("test bounce done");
    pulse(2);
    pulse(2);
    check(nDp[7:0], 8'h00);
    wr(`ADDR_DOUBLE_PRESS, 8'h03);
    pulse(2);
    repeat (50) @(posedge clk);
    pulse(2);
    check(nDp[7:0], 8'h01);
    repeat (450) @(posedge clk);
    pulse(2);
    repeat (400) @(posedge clk);
    pulse(2);
    check(nDp[7:0], 8'h01);
    $display("test double_press done");
    for (int a = 8'h18; a <= 8'h21; a++)
    begin
      rnd(v);
      wr(a[7:0], v);
      rd_exp(a[7:0], v);
    end
    drain();
    wr(`ADDR_COLOUR_FADE, 8'h00);
    wr(`ADDR_PIN_FADE, 8'h00);
    $display("test readback done");
    for (int ch = 0; ch < 6; ch++)
    begin
      rnd(v);
      for (int j = 0; j < 3; j++)
      begin
        wr(8'h18 + ch[7:0], (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : v);
        repeat (3) @(posedge clk);
        count_high(ch, 255, k);
        check(k[7:0], (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : v);
      end
    end
    $display("test duty done");
    wr(`ADDR_PIN_FADE, 8'h05);
    gpMode[1] <= led_gp_pkg::GP_OUTPUT;
    wr(`ADDR_PIN2_VALUE, 8'h01);
    repeat (2) @(posedge clk);
    check({7'h00, gpOut[1]}, 8'h01);
    check({5'h00, gpOe}, 8'h07);
    wr(`ADDR_PIN2_VALUE, 8'h00);
    repeat (2) @(posedge clk);
    check({7'h00, gpOut[1]}, 8'h00);
    rnd(v);
    gpMode[2] <= led_gp_pkg::GP_ANALOG;
    gpIn[2].analog <= v;
    gpMode[0] <= led_gp_pkg::GP_INPUT;
    gpIn[0].level <= 1'b1;
    repeat (2) @(posedge clk);
    rd_exp(`ADDR_PIN3_VALUE, v);
    rd_exp(`ADDR_PIN1_VALUE, 8'h01);
    gpIn[0].level <= 1'b0;
    rd_exp(`ADDR_PIN1_VALUE, 8'h00);
    drain();
    check({5'h00, gpOe}, 8'h02);
    $display("test pin_modes done");
    wr(`ADDR_RED_INTENSITY, 8'h00);
    wr(`ADDR_COLOUR_FADE, 8'h01);
    wr(`ADDR_RED_INTENSITY, 8'hFF);
    repeat (3) @(posedge clk);
    count_high(0, 255, k);
    check({7'h00, k < 40}, 8'h01);
    count_high(0, 255, k);
    check({7'h00, k > 16 && k < 64}, 8'h01);
    repeat (2600) @(posedge clk);
    count_high(0, 255, k);
    check(k[7:0], 8'hFF);
    @(posedge clk);
    rgbFitted <= 1'b0;
    wr(`ADDR_GREEN_INTENSITY, 8'hFF);
    repeat (3) @(posedge clk);
    count_high(1, 255, k);
    check(k[7:0], 8'hFF);
    $display("test fade done");
    end_of_test();
  end
endmodule
